// File: scb_cfg.svh
// constants for the system controller and bus driver
`ifndef SCB_CFG_SVH
`define SCB_CFG_SVH
`define SCB_DATA_W 8
// status byte bit positions
`define SCB_ST_ACK 0
`define SCB_ST_WO_N 1
`define SCB_ST_STACK 2
`define SCB_ST_HALT 3
`define SCB_ST_OUT 4
`define SCB_ST_M1 5
`define SCB_ST_INP 6
`define SCB_ST_MRD 7
`define SCB_STATUS_RST 8'h02
`define SCB_RST7_OPCODE 8'hFF
`define SCB_IDLE_BYTE 8'hFF
`define SCB_MULTI_CYCLES 2'h2
`endif

// File: scb_controller.sv
// system controller: status latch, command decode, bidirectional data buffer
// Overview of operation
// - buffer eight-bit path between processor and system
// - buffer direction comes from read command decode and the write-output status bit
// - latch status byte on strobe falling edge
// - all commands active low from status
// - read commands only while data-in strobe
// - read commands drive system-to-processor direction
// - acknowledge in all three status cycles
// - fill acknowledge in second, third cycles
// - strap drives restart-7 during acknowledge read
// - write commands from write strobe, status
// - bus float input tristates command and system data outputs immediately
// - reads pass system data, writes processor
// - power-on strobe resets held status
`timescale 1ns/100ps
`include "scb_cfg.svh"
module scb_controller (
    input wire logic clock_in,
    input wire logic srst_in,
    input wire logic [7:0] cpu_data_in,
    output logic [7:0] cpu_data_out,
    output logic cpu_data_oe_out,
    input wire logic [7:0] sys_data_in,
    output logic [7:0] sys_data_out,
    output logic sys_data_oe_out,
    input wire logic status_strobe_n_in,
    input wire logic cpu_data_in_strobe_in,
    input wire logic cpu_write_n_in,
    input wire logic hold_ack_in,
    input wire logic bus_float_n_in,
    input wire logic single_rst7_strap_in,
    output logic mem_read_cmd_n_out,
    output logic mem_write_cmd_n_out,
    output logic io_read_cmd_n_out,
    output logic io_write_cmd_n_out,
    output logic int_ack_cmd_n_out,
    output logic cmd_oe_out
);
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic strobe_reg;
    logic strobe_next;
    logic [1:0] fill_cnt_reg;
    logic [1:0] fill_cnt_next;
    scb_pkg::scb_ack_state_type ack_reg;
    scb_pkg::scb_ack_state_type ack_next;
    logic [7:0] cpu_data_reg;
    logic [7:0] cpu_data_next;
    logic [7:0] sys_data_reg;
    logic [7:0] sys_data_next;
    scb_pkg::scb_cmd_type cmd;
    logic strobe_fall;
    logic ack_status;
    logic fill_ack;
    logic read_dir;
    logic write_dir;
    logic float_all;

    // reads a named status bit out of a status byte
    function automatic logic st_bit(input logic [7:0] st, input int pos);
        st_bit = st[pos];
    endfunction

    assign strobe_fall = strobe_reg && !status_strobe_n_in;
    assign float_all = bus_float_n_in;

    // status latch
    always_comb
    begin
        strobe_next = status_strobe_n_in;
        status_next = status_reg;
        if (strobe_fall)
        begin
            status_next = cpu_data_in;
        end
    end

    // synchronous reset stands in for the power-on strobe reset
    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            status_reg <= `SCB_STATUS_RST;
            strobe_reg <= 1'b1;
        end
        else
        begin
            status_reg <= status_next;
            strobe_reg <= strobe_next;
        end
    end

    // held status may only move on a sampled strobe fall
    chk_status_latch: assert property (@(posedge clock_in) disable iff (srst_in)
        (strobe_reg && !status_strobe_n_in) |=> (status_reg == $past(cpu_data_in)))
        else $error("status not latched on strobe fall");
    chk_status_hold: assert property (@(posedge clock_in) disable iff (srst_in)
        !(strobe_reg && !status_strobe_n_in) |=> $stable(status_reg))
        else $error("status changed without strobe fall");
    chk_strobe_track: assert property (@(posedge clock_in) disable iff (srst_in)
        1'b1 |=> (strobe_reg == $past(status_strobe_n_in)))
        else $error("strobe history lost");
    chk_reset_status: assert property (@(posedge clock_in)
        srst_in |=> (status_reg == `SCB_STATUS_RST))
        else $error("status not reset");

    assign ack_status = st_bit(status_reg, `SCB_ST_ACK);

    // acknowledge filler for processors that flag only the first cycle
    always_comb
    begin
        ack_next = ack_reg;
        fill_cnt_next = fill_cnt_reg;
        case (ack_reg)
            scb_pkg::SCB_ACK_IDLE:
            begin
                if (strobe_fall && st_bit(cpu_data_in, `SCB_ST_ACK) && st_bit(cpu_data_in, `SCB_ST_M1))
                begin
                    ack_next = scb_pkg::SCB_ACK_DONE;
                    fill_cnt_next = `SCB_MULTI_CYCLES;
                end
            end
            scb_pkg::SCB_ACK_DONE:
            begin
                // next cycle decides whether fill is needed
                if (strobe_fall)
                begin
                    if (st_bit(cpu_data_in, `SCB_ST_M1) || st_bit(cpu_data_in, `SCB_ST_ACK))
                    begin
                        ack_next = (st_bit(cpu_data_in, `SCB_ST_M1) && st_bit(cpu_data_in, `SCB_ST_ACK))
                            ? scb_pkg::SCB_ACK_DONE : scb_pkg::SCB_ACK_IDLE;
                    end
                    else if (st_bit(cpu_data_in, `SCB_ST_MRD))
                    begin
                        ack_next = scb_pkg::SCB_ACK_FILL;
                        fill_cnt_next = fill_cnt_reg - 2'h1;
                    end
                    else
                    begin
                        ack_next = scb_pkg::SCB_ACK_IDLE;
                    end
                end
            end
            scb_pkg::SCB_ACK_FILL:
            begin
                if (strobe_fall)
                begin
                    if (fill_cnt_reg != 2'h0 && st_bit(cpu_data_in, `SCB_ST_MRD)
                        && !st_bit(cpu_data_in, `SCB_ST_M1))
                    begin
                        fill_cnt_next = fill_cnt_reg - 2'h1;
                    end
                    else
                    begin
                        ack_next = scb_pkg::SCB_ACK_IDLE;
                        fill_cnt_next = 2'h0;
                    end
                end
            end
            default:
            begin
                ack_next = scb_pkg::SCB_ACK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            ack_reg <= scb_pkg::SCB_ACK_IDLE;
            fill_cnt_reg <= 2'h0;
        end
        else
        begin
            ack_reg <= ack_next;
            fill_cnt_reg <= fill_cnt_next;
        end
    end

    // fill only ever follows an acknowledge cycle carrying M1
    chk_fill_count: assert property (@(posedge clock_in) disable iff (srst_in)
        fill_cnt_reg <= `SCB_MULTI_CYCLES)
        else $error("fill count beyond two cycles");
    chk_fill_start: assert property (@(posedge clock_in) disable iff (srst_in)
        (ack_reg == scb_pkg::SCB_ACK_IDLE) |=> (ack_reg != scb_pkg::SCB_ACK_FILL))
        else $error("fill began without acknowledge cycle");
    chk_state_onehot: assert property (@(posedge clock_in) disable iff (srst_in)
        $onehot(ack_reg))
        else $error("acknowledge state not one-hot");

    assign fill_ack = (ack_reg == scb_pkg::SCB_ACK_FILL);

    // gating array; hold acknowledge suppresses memory and I/O reads so another master owns the bus
    always_comb
    begin
        cmd.mem_read_n = !(cpu_data_in_strobe_in && !hold_ack_in && st_bit(status_reg, `SCB_ST_MRD)
            && !fill_ack);
        cmd.io_read_n = !(cpu_data_in_strobe_in && !hold_ack_in && st_bit(status_reg, `SCB_ST_INP));
        cmd.int_ack_n = !(cpu_data_in_strobe_in && (ack_status || fill_ack));
        cmd.mem_write_n = !(!cpu_write_n_in && !st_bit(status_reg, `SCB_ST_OUT)
            && !st_bit(status_reg, `SCB_ST_WO_N));
        cmd.io_write_n = !(!cpu_write_n_in && st_bit(status_reg, `SCB_ST_OUT));
    end

    chk_read_gate: assert property (@(posedge clock_in) disable iff (srst_in)
        !cpu_data_in_strobe_in |-> (mem_read_cmd_n_out && io_read_cmd_n_out && int_ack_cmd_n_out))
        else $error("read command without data-in strobe");
    chk_ack_status: assert property (@(posedge clock_in) disable iff (srst_in)
        (cpu_data_in_strobe_in && status_reg[`SCB_ST_ACK]) |-> !int_ack_cmd_n_out)
        else $error("acknowledge missing in ack status cycle");
    chk_fill_ack: assert property (@(posedge clock_in) disable iff (srst_in)
        (cpu_data_in_strobe_in && fill_ack) |-> (!int_ack_cmd_n_out && mem_read_cmd_n_out))
        else $error("filled acknowledge cycle not decoded");
    chk_mem_read: assert property (@(posedge clock_in) disable iff (srst_in)
        !mem_read_cmd_n_out |-> status_reg[`SCB_ST_MRD])
        else $error("memory read without read status");
    chk_io_read: assert property (@(posedge clock_in) disable iff (srst_in)
        !io_read_cmd_n_out |-> (cpu_data_in_strobe_in && status_reg[`SCB_ST_INP]))
        else $error("io read without strobe and status");
    chk_io_write: assert property (@(posedge clock_in) disable iff (srst_in)
        !io_write_cmd_n_out |-> (!cpu_write_n_in && status_reg[`SCB_ST_OUT]))
        else $error("io write without write strobe and status");
    chk_mem_write: assert property (@(posedge clock_in) disable iff (srst_in)
        !mem_write_cmd_n_out |-> (!cpu_write_n_in && !status_reg[`SCB_ST_OUT] && !status_reg[`SCB_ST_WO_N]))
        else $error("memory write without write strobe and status");
    chk_write_gate: assert property (@(posedge clock_in) disable iff (srst_in)
        cpu_write_n_in |-> (mem_write_cmd_n_out && io_write_cmd_n_out))
        else $error("write command without write strobe");
    chk_hold_release: assert property (@(posedge clock_in) disable iff (srst_in)
        hold_ack_in |-> (mem_read_cmd_n_out && io_read_cmd_n_out))
        else $error("read command during hold acknowledge");

    assign read_dir = !cmd.mem_read_n || !cmd.io_read_n || !cmd.int_ack_n;
    assign write_dir = !st_bit(status_reg, `SCB_ST_WO_N) && !hold_ack_in;

    // data buffer registers; strap supplies the all-ones restart opcode
    always_comb
    begin
        cpu_data_next = sys_data_in;
        if (!cmd.int_ack_n && single_rst7_strap_in)
        begin
            cpu_data_next = `SCB_RST7_OPCODE;
        end
        else if (!read_dir)
        begin
            cpu_data_next = `SCB_IDLE_BYTE;
        end
        sys_data_next = cpu_data_in;
    end

    always_ff @(posedge clock_in)
    begin
        if (srst_in)
        begin
            cpu_data_reg <= `SCB_IDLE_BYTE;
            sys_data_reg <= 8'h00;
        end
        else
        begin
            cpu_data_reg <= cpu_data_next;
            sys_data_reg <= sys_data_next;
        end
    end

    assign cpu_data_out = cpu_data_reg;
    assign sys_data_out = sys_data_reg;
    // processor side enabled under the data-in strobe only
    assign cpu_data_oe_out = cpu_data_in_strobe_in && read_dir;
    assign sys_data_oe_out = !float_all && write_dir && !read_dir;
    assign cmd_oe_out = !float_all;
    assign mem_read_cmd_n_out = cmd.mem_read_n;
    assign mem_write_cmd_n_out = cmd.mem_write_n;
    assign io_read_cmd_n_out = cmd.io_read_n;
    assign io_write_cmd_n_out = cmd.io_write_n;
    assign int_ack_cmd_n_out = cmd.int_ack_n;

    chk_rst7_drive: assert property (@(posedge clock_in) disable iff (srst_in)
        (!int_ack_cmd_n_out && single_rst7_strap_in) |=> (cpu_data_out == `SCB_RST7_OPCODE))
        else $error("restart opcode not driven");
    chk_read_path: assert property (@(posedge clock_in) disable iff (srst_in)
        (!mem_read_cmd_n_out && !single_rst7_strap_in) |=> (cpu_data_out == $past(sys_data_in)))
        else $error("system data not passed on read");
    chk_io_read_path: assert property (@(posedge clock_in) disable iff (srst_in)
        (!io_read_cmd_n_out && int_ack_cmd_n_out) |=> (cpu_data_out == $past(sys_data_in)))
        else $error("port data not passed on io read");
    chk_idle_byte: assert property (@(posedge clock_in) disable iff (srst_in)
        (int_ack_cmd_n_out && mem_read_cmd_n_out && io_read_cmd_n_out) |=> (cpu_data_out == `SCB_IDLE_BYTE))
        else $error("processor data not idle outside reads");
    chk_write_path: assert property (@(posedge clock_in) disable iff (srst_in)
        !mem_write_cmd_n_out |=> (sys_data_out == $past(cpu_data_in)))
        else $error("processor data not passed on write");
    chk_read_dir: assert property (@(posedge clock_in) disable iff (srst_in)
        (!mem_read_cmd_n_out || !io_read_cmd_n_out) |-> (cpu_data_oe_out && !sys_data_oe_out))
        else $error("buffer direction wrong on read");
    chk_cpu_enable: assert property (@(posedge clock_in) disable iff (srst_in)
        cpu_data_oe_out |-> cpu_data_in_strobe_in)
        else $error("processor bus driven without data-in strobe");
    chk_float_all: assert property (@(posedge clock_in) disable iff (srst_in)
        bus_float_n_in |-> (!cmd_oe_out && !sys_data_oe_out))
        else $error("outputs driven while floated");
    chk_float_release: assert property (@(posedge clock_in) disable iff (srst_in)
        !bus_float_n_in |-> cmd_oe_out)
        else $error("commands floated in normal operation");
    chk_hold_sysbus: assert property (@(posedge clock_in) disable iff (srst_in)
        hold_ack_in |-> !sys_data_oe_out)
        else $error("system bus driven during hold acknowledge");
endmodule

// File: scb_pkg.sv
// types for the system controller and bus driver
package scb_pkg;
    typedef struct packed {
        logic mem_read_n;
        logic mem_write_n;
        logic io_read_n;
        logic io_write_n;
        logic int_ack_n;
    } scb_cmd_type;

    typedef struct packed {
        logic [7:0] data;
        logic oe;
    } scb_drive_type;

    typedef enum logic [2:0] {
        SCB_ACK_IDLE = 3'h1,
        SCB_ACK_FILL = 3'h2,
        SCB_ACK_DONE = 3'h4
    } scb_ack_state_type;
endpackage

// File: scb_sys_model.sv
// system-side memory, input port and interrupt source answering read commands
`timescale 1ns/100ps
module scb_sys_model #(
    parameter logic [7:0] MEM_BYTE = 8'h5C,
    parameter logic [7:0] IO_BYTE = 8'h93,
    parameter logic [7:0] ACK_BYTE = 8'hCD
) (
    input wire logic clock_in,
    input wire scb_pkg::scb_cmd_type cmd_in,
    input wire logic cmd_oe_in,
    output logic [7:0] sys_data_out
);
    logic [7:0] churn_reg = 8'hA5;
    scb_pkg::scb_cmd_type cmd_seen;
    // floated command lines sit at the pull-up level
    assign cmd_seen = cmd_in | {5{!cmd_oe_in}};
    // nobody selected: bus shows a changing pattern, never a held value
    always @(posedge clock_in)
        churn_reg <= churn_reg + 8'h3B;
    always_comb
    begin
        if (!cmd_seen.mem_read_n)
            sys_data_out = MEM_BYTE;
        else if (!cmd_seen.io_read_n)
            sys_data_out = IO_BYTE;
        else if (!cmd_seen.int_ack_n)
            sys_data_out = ACK_BYTE;
        else
            sys_data_out = ~churn_reg;
    end
endmodule

// File: tb_top.sv
// self-checking bench for the system controller and bus driver
`timescale 1ns/100ps
module tb_top;
    localparam logic [7:0] MEM_BYTE = 8'h5C;
    localparam logic [7:0] IO_BYTE = 8'h93;
    localparam logic [7:0] ACK_BYTE = 8'hCD;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] cpu_data = 8'h00;
    logic stb_n = 1'b1;
    logic din_stb = 1'b0;
    logic wr_n = 1'b1;
    logic hold = 1'b0;
    logic float_hi = 1'b0;
    logic strap = 1'b0;
    logic [7:0] cpu_q;
    logic [7:0] sys_d;
    logic [7:0] sys_q;
    logic cpu_oe;
    logic sys_oe;
    logic cmd_oe;
    wire scb_pkg::scb_cmd_type cmd;
    int fail_count = 0;
    int total_checks = 0;
    always #4 clk = ~clk;
    scb_controller dut (.clock_in(clk), .srst_in(srst), .cpu_data_in(cpu_data), .cpu_data_out(cpu_q),
        .cpu_data_oe_out(cpu_oe), .sys_data_in(sys_d), .sys_data_out(sys_q), .sys_data_oe_out(sys_oe),
        .status_strobe_n_in(stb_n), .cpu_data_in_strobe_in(din_stb), .cpu_write_n_in(wr_n), .hold_ack_in(hold),
        .bus_float_n_in(float_hi), .single_rst7_strap_in(strap), .mem_read_cmd_n_out(cmd.mem_read_n),
        .mem_write_cmd_n_out(cmd.mem_write_n), .io_read_cmd_n_out(cmd.io_read_n),
        .io_write_cmd_n_out(cmd.io_write_n), .int_ack_cmd_n_out(cmd.int_ack_n), .cmd_oe_out(cmd_oe));
    scb_sys_model #(.MEM_BYTE(MEM_BYTE), .IO_BYTE(IO_BYTE), .ACK_BYTE(ACK_BYTE)) partner (.clock_in(clk),
        .cmd_in(cmd), .cmd_oe_in(cmd_oe), .sys_data_out(sys_d));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // status changes with the strobe fall, half a cycle before the sampling edge
    task automatic latch(input logic [7:0] st);
        @(negedge clk);
        cpu_data = st;
        stb_n = 1'b0;
        @(negedge clk);
        stb_n = 1'b1;
    endtask
    task automatic rd(input logic [7:0] st, input logic [4:0] ecmd, input logic [7:0] edata);
        latch(st);
        @(negedge clk);
        din_stb = 1'b1;
        #1;
        chk("read command", cmd, ecmd);
        chk("processor bus enable", cpu_oe, 1'b1);
        chk("system bus enable", sys_oe, 1'b0);
        @(negedge clk);
        chk("processor read data", cpu_q, edata);
        din_stb = 1'b0;
        #1;
        chk("idle command", cmd, 5'h1F);
    endtask
    task automatic wr(input logic [7:0] st, input logic [4:0] ecmd, input logic [7:0] d);
        latch(st);
        @(negedge clk);
        wr_n = 1'b0;
        cpu_data = d;
        #1;
        chk("write command", cmd, ecmd);
        chk("system bus enable", sys_oe, 1'b1);
        @(negedge clk);
        chk("system write data", sys_q, d);
        wr_n = 1'b1;
    endtask
    task automatic t_fill();
        rd(8'h23, 5'h1E, ACK_BYTE);
        rd(8'h82, 5'h1E, ACK_BYTE);
        rd(8'h82, 5'h1E, ACK_BYTE);
        rd(8'h82, 5'h0F, MEM_BYTE);
    endtask
    task automatic t_hold(input logic [7:0] st);
        latch(st);
        @(negedge clk);
        hold = 1'b1;
        din_stb = 1'b1;
        #1;
        chk("held read command", cmd, 5'h1F);
        chk("held processor enable", cpu_oe, 1'b0);
        chk("held system enable", sys_oe, 1'b0);
        @(negedge clk);
        din_stb = 1'b0;
        hold = 1'b0;
    endtask
    // write status would drive the system bus but for hold
    task automatic t_hold_write();
        latch(8'h00);
        @(negedge clk);
        hold = 1'b1;
        #1;
        chk("held write enable", sys_oe, 1'b0);
        @(negedge clk);
        hold = 1'b0;
        #1;
        chk("released write enable", sys_oe, 1'b1);
    endtask
    // no clock edge lies between the float change and the check
    task automatic t_float();
        latch(8'h00);
        @(negedge clk);
        wr_n = 1'b0;
        float_hi = 1'b1;
        #1;
        chk("floated command enable", cmd_oe, 1'b0);
        chk("floated system enable", sys_oe, 1'b0);
        @(negedge clk);
        float_hi = 1'b0;
        #1;
        chk("restored command enable", cmd_oe, 1'b1);
        chk("restored system enable", sys_oe, 1'b1);
        wr_n = 1'b1;
    endtask
    task automatic close_out();
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        #1;
        chk("reset commands", cmd, 5'h1F);
        chk("reset processor data", cpu_q, 8'hFF);
        chk("reset system data", sys_q, 8'h00);
        rd(8'h82, 5'h0F, MEM_BYTE);
        rd(8'h42, 5'h1B, IO_BYTE);
        rd(8'hA2, 5'h0F, MEM_BYTE);
        wr(8'h00, 5'h17, 8'h3C);
        wr(8'h10, 5'h1D, 8'hC3);
        t_fill();
        rd(8'h23, 5'h1E, ACK_BYTE);
        rd(8'h03, 5'h1E, ACK_BYTE);
        rd(8'h03, 5'h1E, ACK_BYTE);
        strap = 1'b1;
        rd(8'h23, 5'h1E, 8'hFF);
        strap = 1'b0;
        t_hold(8'h42);
        t_hold(8'h82);
        t_hold_write();
        t_float();
        close_out();
    end
    // tests need about 80 cycles
    initial
    begin
        repeat (1000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule
